// ### src/pcsr_mdio_engine.sv
`timescale 1ns/10ps
`default_nettype none
module pcsr_mdio_engine (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // register side
  pcsr_mgmt_if.engine mg
);
  import pcsr_pkg::*;
  logic [2:0] mdc_r;
  logic [1:0] dat_r;
  logic rise;
  logic bit_in;
  pcsr_mdio_st_t st_r;
  logic [5:0] ones_r;
  logic [3:0] cnt_r;
  logic [11:0] hdr_r;
  logic [15:0] sh_r;
  logic is_rd;
  logic hit;

  // mdc needs several clk periods per half cycle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mdc_r <= 3'h0;
      dat_r <= 2'h0;
    end
    else
    begin
      mdc_r <= {mdc_r[1:0], mdc_in};
      dat_r <= {dat_r[0], mdio_in};
    end
  end

  assign rise = mdc_r[1] & ~mdc_r[2];
  assign bit_in = dat_r[1];
  assign is_rd = (hdr_r[11:10] == OP_READ);
  assign hit = (hdr_r[9:5] == mg.phy_addr);
  assign mg.addr = hdr_r[4:0];

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st_r <= M_IDLE;
      ones_r <= 6'h00;
      cnt_r <= 4'h0;
      hdr_r <= 12'h000;
      sh_r <= 16'h0000;
      mdio_out <= 1'h0;
      mdio_oe_out <= 1'h0;
      mg.rd <= 1'h0;
      mg.wr <= 1'h0;
      mg.wdata <= 16'h0000;
    end
    else
    begin
      mg.rd <= 1'h0;
      mg.wr <= 1'h0;
      // snapshot taken before clear-on-read lands
      if (mg.rd)
        sh_r <= mg.rdata;
      if (rise)
      begin
        case (st_r)
          M_IDLE:
          begin
            if (bit_in)
              ones_r <= (ones_r == PREAMBLE_LEN) ? ones_r : ones_r + 6'h01;
            else
            begin
              if (ones_r == PREAMBLE_LEN || mg.pre_sup)
                st_r <= M_START;
              ones_r <= 6'h00;
            end
          end
          M_START:
          begin
            st_r <= bit_in ? M_HDR : M_IDLE;
            cnt_r <= 4'h0;
          end
          M_HDR:
          begin
            hdr_r <= {hdr_r[10:0], bit_in};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == HDR_LAST)
            begin
              st_r <= M_TA;
              cnt_r <= 4'h0;
            end
          end
          M_TA:
          begin
            cnt_r <= 4'h1;
            if (cnt_r == 4'h0)
            begin
              mg.rd <= is_rd & hit;
              mdio_oe_out <= is_rd & hit;
              mdio_out <= 1'h0;
            end
            else
            begin
              mdio_out <= sh_r[15];
              sh_r <= {sh_r[14:0], 1'h0};
              st_r <= M_DATA;
              cnt_r <= 4'h0;
            end
          end
          M_DATA:
          begin
            cnt_r <= cnt_r + 4'h1;
            mdio_out <= sh_r[15];
            sh_r <= {sh_r[14:0], bit_in};
            if (cnt_r == DATA_LAST)
            begin
              st_r <= M_IDLE;
              mdio_oe_out <= 1'h0;
              mg.wr <= (hdr_r[11:10] == OP_WRITE) & hit;
              mg.wdata <= {sh_r[14:0], bit_in};
            end
          end
          default:
            st_r <= M_IDLE;
        endcase
      end
    end
  end
endmodule : pcsr_mdio_engine
`default_nettype wire

// ### src/pcsr_mgmt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pcsr_mgmt_if;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic pre_sup;
  logic [4:0] phy_addr;
  modport engine (output addr, wdata, wr, rd,
                  input rdata, pre_sup, phy_addr);
  modport regs (input addr, wdata, wr, rd,
                output rdata, pre_sup, phy_addr);
endinterface : pcsr_mgmt_if
`default_nettype wire

// ### src/pcsr_pkg.sv
// Contract
// - low power drives MAC outputs low and tri-states the pair transmitter
// - entering low power by bit keeps registers, reloads latching bits
// - reset loads every management bit with its default
// - isolate floats all MAC outputs and ignores MAC transmit inputs
// - isolate defaults to one when PHY address is zero, else zero
// - restart negotiation only honoured in software mode
// - restart bit set by write, cleared once negotiation has begun
// - writes setting restart are ignored while negotiation is disabled
// - hardware mode takes duplex from the duplex select pin
// - software mode duplex from negotiation result or from the duplex bit
// - duplex bit has no effect during loopback
// - collision test clear keeps collision from following transmit enable
// - collision test set makes collision follow transmit enable in time
// - reserved low control bits read zero
// - status reads T4 zero, negotiation ability and extended ability one
// - four capability bits default one, writable only under override
// - negotiation complete reads progress state and latches high
// - jabber and remote fault latch high, link status latches low
// - preamble suppression bit defaults zero; one accepts bare frames
// - latched remote fault clears when the status register is read
package pcsr_pkg;
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;
  localparam logic [4:0] ISO_PHY_ADDR = 5'h00;
  // control register reset values
  localparam logic CTL_LOOP_RST = 1'h0;
  localparam logic CTL_RATE_RST = 1'h1;
  localparam logic CTL_AN_EN_RST = 1'h1;
  localparam logic CTL_LOW_PWR_RST = 1'h0;
  localparam logic CTL_DUPLEX_RST = 1'h0;
  localparam logic CTL_COL_TEST_RST = 1'h0;
  // status register reset values
  localparam logic [3:0] STS_CAP_RST = 4'hF;
  localparam logic [3:0] STS_RSV_RST = 4'h0;
  localparam logic STS_PRE_SUP_RST = 1'h0;
  localparam logic STS_LATCH_RST = 1'h0;
  // control field positions
  localparam int CTL_RESET = 15;
  localparam int CTL_LOOP = 14;
  localparam int CTL_RATE = 13;
  localparam int CTL_AN_EN = 12;
  localparam int CTL_LOW_PWR = 11;
  localparam int CTL_ISOLATE = 10;
  localparam int CTL_AN_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int CTL_COL_TEST = 7;
  // status field positions
  localparam int STS_CAP_HI = 14;
  localparam int STS_CAP_LO = 11;
  localparam int STS_RSV_HI = 10;
  localparam int STS_RSV_LO = 7;
  localparam int STS_PRE_SUP = 6;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int BIT_TIME_NS = 100;
  localparam int COL_ON_BITS = 512;
  localparam int COL_OFF_BITS = 4;
  localparam int COL_ON_CYC = COL_ON_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int COL_OFF_CYC = COL_OFF_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // management frame
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_START = 5'h02,
    M_HDR = 5'h04,
    M_TA = 5'h08,
    M_DATA = 5'h10
  } pcsr_mdio_st_t;
endpackage : pcsr_pkg

// ### src/pcsr_top.sv
`timescale 1ns/10ps
`default_nettype none
module pcsr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // strap and select pins
  input wire logic hard_soft_select_pin_in,
  input wire logic duplex_select_pin_in,
  input wire logic [4:0] phy_addr_in,
  // extended control, same clock
  input wire logic override_write_en_in,
  // core status, same clock
  input wire logic an_complete_in,
  input wire logic an_started_in,
  input wire logic an_result_full_in,
  input wire logic remote_fault_in,
  input wire logic link_up_in,
  input wire logic jabber_in,
  // core receive side, same clock
  input wire logic core_tx_clk_in,
  input wire logic core_rx_clk_in,
  input wire logic core_rx_dv_in,
  input wire logic core_rx_er_in,
  input wire logic [3:0] core_rxd_in,
  input wire logic core_crs_in,
  input wire logic core_col_in,
  // MAC pins
  input wire logic txen_in,
  input wire logic [3:0] txd_in,
  input wire logic txer_in,
  output logic tx_clk_out,
  output logic rx_clk_out,
  output logic rx_dv_out,
  output logic rx_er_out,
  output logic [3:0] rxd_out,
  output logic crs_out,
  output logic col_out,
  output logic mac_oe_out,
  // toward core transmit
  output logic core_txen_out,
  output logic [3:0] core_txd_out,
  output logic core_txer_out,
  // twisted pair and mode outputs
  output logic pair_tx_oe_out,
  output logic tx_pair_tristate_out,
  output logic low_power_out,
  output logic loopback_out,
  output logic rate_100_out,
  output logic an_enable_out,
  output logic an_restart_out,
  output logic duplex_full_out
);
  import pcsr_pkg::*;
  localparam int COL_OFF_LIM = COL_OFF_CYC;

  pcsr_mgmt_if mg ();
  logic [12:0] pin_s1_r;
  logic [12:0] pin_s2_r;
  logic hs_sw;
  logic dpx_pin;
  logic [4:0] pa;
  logic [5:0] tx_pins;
  logic [1:0] strap_r;
  logic soft_rst_r;
  logic loop_r;
  logic rate_r;
  logic an_en_r;
  logic low_pwr_r;
  logic low_pwr_d_r;
  logic iso_r;
  logic restart_r;
  logic duplex_r;
  logic col_test_r;
  logic [3:0] cap_r;
  logic [3:0] rsv_r;
  logic pre_sup_r;
  logic an_done_r;
  logic rfault_r;
  logic jab_r;
  logic link_r;
  logic wr_ctl;
  logic wr_sts;
  logic rd_sts;
  logic lp_enter;
  logic restart_set;
  logic [15:0] wd;

  pcsr_mdio_engine u_engine (
    .clk_in (clk_in),
    .rst_b_in (rst_b_in),
    .mdc_in (mdc_in),
    .mdio_in (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe_out (mdio_oe_out),
    .mg (mg.engine)
  );

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_s1_r <= 13'h0000;
      pin_s2_r <= 13'h0000;
    end
    else
    begin
      pin_s1_r <= {hard_soft_select_pin_in, duplex_select_pin_in,
                   phy_addr_in, txen_in, txd_in, txer_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign hs_sw = pin_s2_r[12];
  assign dpx_pin = pin_s2_r[11];
  assign pa = pin_s2_r[10:6];
  assign tx_pins = pin_s2_r[5:0];
  assign wd = mg.wdata;
  // accesses are shut out while a software reset runs
  assign wr_ctl = mg.wr && mg.addr == REG_CONTROL && !soft_rst_r;
  assign wr_sts = mg.wr && mg.addr == REG_STATUS && !soft_rst_r;
  assign rd_sts = mg.rd && mg.addr == REG_STATUS && !soft_rst_r;
  assign lp_enter = low_pwr_r & ~low_pwr_d_r;
  assign restart_set = wr_ctl && wd[CTL_AN_RESTART] && an_en_r
                       && hs_sw;
  assign mg.pre_sup = pre_sup_r;
  assign mg.phy_addr = pa;

  // straps are only trusted once through the synchroniser
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      strap_r <= STRAP_WAIT;
    else if (strap_r != 2'h0)
      strap_r <= strap_r - 2'h1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      soft_rst_r <= 1'h0;
      loop_r <= CTL_LOOP_RST;
      rate_r <= CTL_RATE_RST;
      an_en_r <= CTL_AN_EN_RST;
      low_pwr_r <= CTL_LOW_PWR_RST;
      iso_r <= 1'h0;
      duplex_r <= CTL_DUPLEX_RST;
      col_test_r <= CTL_COL_TEST_RST;
    end
    else if (soft_rst_r)
    begin
      soft_rst_r <= 1'h0;
      loop_r <= CTL_LOOP_RST;
      rate_r <= CTL_RATE_RST;
      an_en_r <= CTL_AN_EN_RST;
      low_pwr_r <= CTL_LOW_PWR_RST;
      iso_r <= (pa == ISO_PHY_ADDR);
      duplex_r <= CTL_DUPLEX_RST;
      col_test_r <= CTL_COL_TEST_RST;
    end
    else
    begin
      if (strap_r == 2'h1)
        iso_r <= (pa == ISO_PHY_ADDR);
      if (wr_ctl && wd[CTL_RESET])
        soft_rst_r <= 1'h1;
      else if (wr_ctl)
      begin
        loop_r <= wd[CTL_LOOP];
        rate_r <= wd[CTL_RATE];
        an_en_r <= wd[CTL_AN_EN];
        low_pwr_r <= wd[CTL_LOW_PWR];
        iso_r <= wd[CTL_ISOLATE];
        duplex_r <= wd[CTL_DUPLEX];
        col_test_r <= wd[CTL_COL_TEST];
      end
    end
  end

  // a fresh write beats the start indication in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      restart_r <= 1'h0;
    else if (soft_rst_r)
      restart_r <= 1'h0;
    else if (restart_set)
      restart_r <= 1'h1;
    else if (an_started_in)
      restart_r <= 1'h0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      low_pwr_d_r <= 1'h0;
      cap_r <= STS_CAP_RST;
      rsv_r <= STS_RSV_RST;
      pre_sup_r <= STS_PRE_SUP_RST;
    end
    else
    begin
      low_pwr_d_r <= low_pwr_r;
      if (soft_rst_r)
      begin
        cap_r <= STS_CAP_RST;
        rsv_r <= STS_RSV_RST;
        pre_sup_r <= STS_PRE_SUP_RST;
      end
      else if (wr_sts && override_write_en_in)
      begin
        cap_r <= wd[STS_CAP_HI:STS_CAP_LO];
        rsv_r <= wd[STS_RSV_HI:STS_RSV_LO];
        pre_sup_r <= wd[STS_PRE_SUP];
      end
    end
  end

  // a read reloads the live state, so an event in that cycle survives
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      an_done_r <= STS_LATCH_RST;
      rfault_r <= STS_LATCH_RST;
      jab_r <= STS_LATCH_RST;
      link_r <= STS_LATCH_RST;
    end
    else if (soft_rst_r || lp_enter)
    begin
      an_done_r <= STS_LATCH_RST;
      rfault_r <= STS_LATCH_RST;
      jab_r <= STS_LATCH_RST;
      link_r <= STS_LATCH_RST;
    end
    else if (rd_sts)
    begin
      an_done_r <= an_complete_in & an_en_r;
      rfault_r <= remote_fault_in;
      jab_r <= jabber_in;
      link_r <= link_up_in;
    end
    else
    begin
      an_done_r <= an_done_r | (an_complete_in & an_en_r);
      rfault_r <= rfault_r | remote_fault_in;
      jab_r <= jab_r | jabber_in;
      link_r <= link_r & link_up_in;
    end
  end

  always_comb
  begin
    mg.rdata = 16'h0000;
    case (mg.addr)
      REG_CONTROL:
        mg.rdata = {soft_rst_r, loop_r, rate_r, an_en_r, low_pwr_r, iso_r,
                    restart_r, duplex_r, col_test_r, 7'h00};
      REG_STATUS:
        mg.rdata = {1'h0, cap_r, rsv_r, pre_sup_r, an_done_r, rfault_r,
                    1'h1, link_r, jab_r, 1'h1};
      default:
        mg.rdata = 16'h0000;
    endcase
  end

  // in software mode loopback is treated as full duplex
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      duplex_full_out <= 1'h0;
    else if (!hs_sw)
      duplex_full_out <= dpx_pin;
    else if (loop_r)
      duplex_full_out <= 1'h1;
    else if (an_en_r)
      duplex_full_out <= an_result_full_in;
    else
      duplex_full_out <= duplex_r;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mac_oe_out <= 1'h0;
      {tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out} <= 4'h0;
      rxd_out <= 4'h0;
      crs_out <= 1'h0;
      col_out <= 1'h0;
      {core_txen_out, core_txd_out, core_txer_out} <= 6'h00;
    end
    else
    begin
      mac_oe_out <= ~iso_r;
      if (low_pwr_r)
      begin
        {tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out} <= 4'h0;
        rxd_out <= 4'h0;
        crs_out <= 1'h0;
        col_out <= 1'h0;
      end
      else
      begin
        {tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out} <=
          {core_tx_clk_in, core_rx_clk_in, core_rx_dv_in, core_rx_er_in};
        rxd_out <= core_rxd_in;
        crs_out <= core_crs_in;
        if (col_test_r)
          col_out <= tx_pins[5];
        else
          col_out <= core_col_in & ~loop_r;
      end
      if (iso_r || low_pwr_r)
        {core_txen_out, core_txd_out, core_txer_out} <= 6'h00;
      else
        {core_txen_out, core_txd_out, core_txer_out} <= tx_pins;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pair_tx_oe_out <= 1'h1;
      tx_pair_tristate_out <= 1'h0;
      low_power_out <= 1'h0;
      loopback_out <= 1'h0;
      rate_100_out <= 1'h0;
      an_enable_out <= 1'h0;
      an_restart_out <= 1'h0;
    end
    else
    begin
      pair_tx_oe_out <= ~low_pwr_r;
      tx_pair_tristate_out <= low_pwr_r;
      low_power_out <= low_pwr_r;
      loopback_out <= loop_r;
      rate_100_out <= rate_r;
      an_enable_out <= an_en_r;
      an_restart_out <= restart_r;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_lp_out;
    low_pwr_r |=> !rx_dv_out && rxd_out == 4'h0 && !pair_tx_oe_out;
  endproperty
  a_lp_out: assert property (p_lp_out) else $error("low power outputs");
  property p_lp_latch;
    $rose(low_pwr_r) |=> !an_done_r && !rfault_r && !jab_r && !link_r;
  endproperty
  a_lp_latch: assert property (p_lp_latch) else $error("latch reload");
  property p_soft_rst;
    soft_rst_r |=> !low_pwr_r && an_en_r && cap_r == STS_CAP_RST && !link_r;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset");
  property p_iso;
    iso_r |=> !mac_oe_out && !core_txen_out;
  endproperty
  a_iso: assert property (p_iso) else $error("isolate outputs");
  property p_iso_strap;
    strap_r == 2'h1 && !wr_ctl && !soft_rst_r
      |=> iso_r == ($past(pa) == ISO_PHY_ADDR);
  endproperty
  a_iso_strap: assert property (p_iso_strap) else $error("isolate strap");
  property p_rst_hw;
    !hs_sw && !restart_r |=> !restart_r;
  endproperty
  a_rst_hw: assert property (p_rst_hw) else $error("restart in hw");
  property p_rst_clr;
    restart_r && an_started_in && !restart_set |=> !restart_r ##1 !an_restart_out;
  endproperty
  a_rst_clr: assert property (p_rst_clr) else $error("restart clear");
  property p_rst_an_off;
    !an_en_r && !restart_r |=> !restart_r;
  endproperty
  a_rst_an_off: assert property (p_rst_an_off) else $error("restart an off");
  property p_dpx_hw;
    !hs_sw |=> duplex_full_out == $past(dpx_pin);
  endproperty
  a_dpx_hw: assert property (p_dpx_hw) else $error("hw duplex");
  property p_dpx_sw;
    hs_sw && !an_en_r && !loop_r |=> duplex_full_out == $past(duplex_r);
  endproperty
  a_dpx_sw: assert property (p_dpx_sw) else $error("sw duplex");
  property p_dpx_loop;
    hs_sw && loop_r |=> duplex_full_out;
  endproperty
  a_dpx_loop: assert property (p_dpx_loop) else $error("loop duplex");
  property p_col_off;
    !col_test_r && !core_col_in |=> !col_out;
  endproperty
  a_col_off: assert property (p_col_off) else $error("collision idle");
  property p_col_on;
    $rose(txen_in) ##1 (col_test_r && !low_pwr_r && txen_in)[*3] |=> col_out;
  endproperty
  a_col_on: assert property (p_col_on) else $error("collision on");
  property p_col_fall;
    $fell(txen_in) && col_test_r && !core_col_in
      |-> ##[1:COL_OFF_LIM] !col_out;
  endproperty
  a_col_fall: assert property (p_col_fall) else $error("collision off");
  property p_rsv;
    mg.addr == REG_CONTROL |-> mg.rdata[6:0] == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved nonzero");
  property p_fixed;
    mg.addr == REG_STATUS |-> !mg.rdata[15] && mg.rdata[3] && mg.rdata[0];
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed status bits");
  property p_cw_lock;
    wr_sts && !override_write_en_in |=> $stable(cap_r) && $stable(rsv_r);
  endproperty
  a_cw_lock: assert property (p_cw_lock) else $error("override lock");
  property p_an_hold;
    an_done_r && !rd_sts && !soft_rst_r && !lp_enter |=> an_done_r;
  endproperty
  a_an_hold: assert property (p_an_hold) else $error("an done latch");
  property p_link_ll;
    !link_up_in |=> !link_r;
  endproperty
  a_link_ll: assert property (p_link_ll) else $error("link latch low");
  property p_pre_sup;
    wr_sts && override_write_en_in |=> pre_sup_r == $past(wd[STS_PRE_SUP]);
  endproperty
  a_pre_sup: assert property (p_pre_sup) else $error("preamble bit");
  property p_rf_clr;
    rd_sts && !remote_fault_in |=> !rfault_r;
  endproperty
  a_rf_clr: assert property (p_rf_clr) else $error("fault clear");
  property p_rsv_cw;
    wr_sts && override_write_en_in |=> rsv_r == $past(wd[10:7]);
  endproperty
  a_rsv_cw: assert property (p_rsv_cw) else $error("override reserved");

  c_restart: cover property (restart_set ##[1:20] an_started_in);
  c_sts_read: cover property (rd_sts && rfault_r);
  c_lp_enter: cover property ($rose(low_pwr_r));
  c_col_test: cover property (col_test_r && col_out);
endmodule : pcsr_top
`default_nettype wire

// ### verif/pcsr_sta_model.sv
`timescale 1ns/10ps
`default_nettype none
module pcsr_sta_model (
  // clock
  input wire logic clk_in,
  // device management pins
  input wire logic mdio_dev_in,
  input wire logic mdio_oe_in,
  output logic mdc_out,
  output logic mdio_line_out
);
  import pcsr_pkg::*;
  logic drv_r;
  logic drv_en_r;
  // pull-up holds the line high when nobody drives
  assign mdio_line_out = mdio_oe_in ? mdio_dev_in :
                         (drv_en_r ? drv_r : 1'h1);
  initial
  begin
    mdc_out = 1'h0;
    drv_r = 1'h1;
    drv_en_r = 1'h0;
  end
  // 16 clocks a bit keeps mdc well under clk/8
  task automatic tick(input logic b, output logic s);
    drv_r = b;
    repeat (8) @(negedge clk_in);
    mdc_out = 1'h1;
    s = mdio_line_out;
    repeat (8) @(negedge clk_in);
    mdc_out = 1'h0;
  endtask : tick
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
    drv_en_r = 1'h1;
    for (int i = 63; i >= 0; i--)
    begin
      if (i == 17 && op == OP_READ)
        drv_en_r = 1'h0;
      tick(f[i], s);
      rd[i[3:0]] = s;
    end
    drv_en_r = 1'h0;
  endtask : frame
endmodule : pcsr_sta_model
`default_nettype wire

// ### verif/tb_pcsr_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pcsr_top;
  import pcsr_pkg::*;
  logic clk_in, rst_b_in, mdc_in, mdio_in, mdio_out, mdio_oe_out;
  logic hard_soft_select_pin_in, duplex_select_pin_in, override_write_en_in;
  logic [4:0] phy_addr_in;
  logic an_complete_in, an_started_in, an_result_full_in, remote_fault_in;
  logic link_up_in, jabber_in, core_tx_clk_in, core_rx_clk_in, core_rx_dv_in;
  logic core_rx_er_in, core_crs_in, core_col_in, txen_in, txer_in;
  logic [3:0] core_rxd_in, txd_in, rxd_out, core_txd_out;
  logic tx_clk_out, rx_clk_out, rx_dv_out, rx_er_out, crs_out, col_out;
  logic mac_oe_out, core_txen_out, core_txer_out, pair_tx_oe_out;
  logic tx_pair_tristate_out, low_power_out, loopback_out, rate_100_out;
  logic an_enable_out, an_restart_out, duplex_full_out;
  logic [15:0] rd;
  // hw pin, duplex pin, an result, control word, expected duplex
  logic [19:0] dtab [7] = '{20'h46201, 20'h06200, 20'h84201, 20'h84000,
                            20'hA6001, 20'h86200, 20'h8C001};
  int n_mismatch = 0;
  int checks_done = 0;
  pcsr_top i_pcsr_top (.*);
  pcsr_sta_model i_pcsr_sta_model (.clk_in, .mdio_dev_in(mdio_out),
    .mdio_oe_in(mdio_oe_out), .mdc_out(mdc_in), .mdio_line_out(mdio_in));
  initial
  begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e, string m);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_pcsr_sta_model.frame(OP_WRITE, phy_addr_in, ra, d, rd);
  endtask : wr
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e, string m);
    i_pcsr_sta_model.frame(OP_READ, phy_addr_in, ra, 16'h0000, rd);
    chk(rd, e, m);
  endtask : rdc
  task automatic rst(input logic [4:0] a);
    phy_addr_in = a;
    rst_b_in = 1'h0;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'h1;
    repeat (8) @(negedge clk_in);
  endtask : rst
  task automatic wait_col(input logic v, input int lim, string m);
    int n;
    n = 0;
    while (col_out !== v && n < lim)
    begin
      @(negedge clk_in);
      n++;
    end
    chk(col_out, v, m);
  endtask : wait_col
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    test_done;
  end
  initial
  begin
    {rst_b_in, phy_addr_in, override_write_en_in, an_complete_in} = 8'h00;
    {an_started_in, an_result_full_in, remote_fault_in, link_up_in} = 4'h0;
    {jabber_in, core_tx_clk_in, core_rx_clk_in, core_rx_dv_in} = 4'h0;
    {core_rx_er_in, core_crs_in, core_col_in, txen_in, txer_in} = 5'h00;
    {core_rxd_in, txd_in, duplex_select_pin_in} = 9'h000;
    hard_soft_select_pin_in = 1'h1;
    rst(5'h00);
    chk(mac_oe_out, 1'h0, "iso strap");
    rdc(REG_CONTROL, 16'h3400, "ctl a0");
    rst(5'h03);
    chk(mac_oe_out, 1'h1, "no iso");
    chk({loopback_out, rate_100_out, an_enable_out}, 16'h0003, "mode");
    rdc(REG_CONTROL, 16'h3000, "ctl dflt");
    rdc(REG_STATUS, 16'h7809, "sts dflt");
    $display("test reset done");
    link_up_in = 1'h1;
    an_complete_in = 1'h1;
    rdc(REG_STATUS, 16'h7829, "an done");
    {remote_fault_in, jabber_in, link_up_in} = 3'h6;
    repeat (2) @(negedge clk_in);
    {remote_fault_in, jabber_in, link_up_in} = 3'h1;
    rdc(REG_STATUS, 16'h783B, "latched");
    rdc(REG_STATUS, 16'h782D, "live");
    override_write_en_in = 1'h1;
    wr(REG_STATUS, 16'h4440);
    override_write_en_in = 1'h0;
    rdc(REG_STATUS, 16'h446D, "ovr");
    wr(REG_STATUS, 16'h7F89);
    rdc(REG_STATUS, 16'h446D, "no ovr");
    $display("test status done");
    an_complete_in = 1'h0;
    remote_fault_in = 1'h1;
    repeat (2) @(negedge clk_in);
    remote_fault_in = 1'h0;
    {core_tx_clk_in, core_rx_er_in, core_rx_dv_in, core_crs_in,
      core_rx_clk_in, core_rxd_in} = 9'h1FF;
    repeat (2) @(negedge clk_in);
    chk({tx_clk_out, rx_er_out, rx_dv_out, crs_out, rx_clk_out, rxd_out},
      16'h01FF, "mac pass");
    wr(REG_CONTROL, 16'h3800);
    chk({low_power_out, tx_pair_tristate_out, pair_tx_oe_out, rx_dv_out,
      crs_out, rx_clk_out, tx_clk_out, rx_er_out, rxd_out}, 16'h0C00,
      "low pwr");
    rdc(REG_STATUS, 16'h4449, "lp sts");
    rdc(REG_CONTROL, 16'h3800, "lp ctl");
    wr(REG_CONTROL, 16'h8000);
    rdc(REG_STATUS, 16'h7809, "sw rst");
    rdc(REG_CONTROL, 16'h3000, "sw rst ctl");
    $display("test low power done");
    {txen_in, txer_in, txd_in} = 6'h3F;
    wr(REG_CONTROL, 16'h3400);
    chk({mac_oe_out, core_txen_out}, 16'h0000, "iso");
    wr(REG_CONTROL, 16'h3000);
    chk({mac_oe_out, core_txen_out, core_txd_out, core_txer_out, col_out},
      16'h00FE, "run");
    {txen_in, txer_in, txd_in} = 6'h00;
    wr(REG_CONTROL, 16'h3200);
    chk(an_restart_out, 1'h1, "restart");
    rdc(REG_CONTROL, 16'h3200, "rs set");
    an_started_in = 1'h1;
    rdc(REG_CONTROL, 16'h3000, "rs clr");
    an_started_in = 1'h0;
    wr(REG_CONTROL, 16'h2000);
    wr(REG_CONTROL, 16'h2200);
    rdc(REG_CONTROL, 16'h2000, "rs an off");
    wr(REG_CONTROL, 16'h3000);
    hard_soft_select_pin_in = 1'h0;
    wr(REG_CONTROL, 16'h3200);
    chk(an_restart_out, 1'h0, "rs hw");
    $display("test isolate restart done");
    foreach (dtab[k])
    begin
      {hard_soft_select_pin_in, duplex_select_pin_in, an_result_full_in} =
        dtab[k][19:17];
      wr(REG_CONTROL, dtab[k][16:1]);
      chk(duplex_full_out, dtab[k][0], "duplex");
    end
    wr(REG_CONTROL, 16'h6080);
    chk({loopback_out, rate_100_out, an_enable_out}, 16'h0006, "lp");
    txen_in = 1'h1;
    wait_col(1'h1, COL_ON_CYC, "col on");
    txen_in = 1'h0;
    wait_col(1'h0, COL_OFF_CYC, "col off");
    $display("test duplex collision done");
    test_done;
  end
endmodule : tb_pcsr_top
`default_nettype wire
